// *** line_coder_defines.svh ***
// Purpose: register map, field positions and reset values of the line coder
// Assumes: 4-bit word-aligned register addresses, 32-bit data
// Notes: definitions only
`ifndef LINE_CODER_DEFINES_SVH
`define LINE_CODER_DEFINES_SVH

`define LC_ADDR_W 4
`define LC_CTRL_ADDR 4'h0
`define LC_STAT_ADDR 4'h4
`define LC_DIV_ADDR 4'h8

`define LC_MODE_LSB 0
`define LC_MODE_MSB 1
`define LC_ROLE_LSB 2
`define LC_ROLE_MSB 3
`define LC_CONN_LSB 4
`define LC_CONN_MSB 5
`define LC_CTRL_W 6
`define LC_CTRL_RST 6'h00

`define LC_DIV_W 16
`define LC_DIV_RST 16'h0004

`define LC_ST_RXBIT 0
`define LC_ST_TXLINE 1
`define LC_ST_REC 2
`define LC_ST_RXCNT_LSB 8
`define LC_ST_RXCNT_MSB 15
`define LC_ST_TXCNT_LSB 16
`define LC_ST_TXCNT_MSB 23
`define LC_CNT_W 8

`endif

// *** line_coder_pkg.sv ***
// Purpose: shared types of the line coder
// Assumes: nothing
// Notes: encodings follow declaration order
`default_nettype none
package line_coder_pkg;
	typedef enum logic [1:0] {
		MODE_NRZ_CLK,
		MODE_EXT_TX,
		MODE_NRZI_CLK,
		MODE_NRZI_REC
	} clk_mode_t;
	typedef enum logic [1:0] {
		ROLE_DTE,
		ROLE_DCE,
		ROLE_MON,
		ROLE_SPARE
	} port_role_t;
endpackage
`default_nettype wire

// *** level_sync.sv ***
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: bits are independent levels
// Notes: first stage is read only by the second
`default_nettype none
module level_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// *** edge_phase_tracker.sv ***
// Purpose: recovers bit timing from transitions of an oversampled line
// Assumes: line is already synchronised to clk
// Notes: phase restarts on every transition, sample taken half a bit later
`default_nettype none
module edge_phase_tracker #(
	parameter int CW = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic enable,
	input wire logic [CW-1:0] half_period,
	// line and strobe
	input wire logic line,
	output logic sample_pulse
);
	logic prev_r;
	logic [CW:0] phase_r;
	logic [CW:0] full;
	logic trans;

	assign full = {half_period, 1'b0};
	assign trans = line ^ prev_r;

	always_ff @(posedge clk) begin
		if (!reset_n)
			prev_r <= 1'b1;
		else
			prev_r <= line;
	end

	// long runs without edges free-run at the nominal rate
	always_ff @(posedge clk) begin
		if (!reset_n || !enable)
			phase_r <= '0;
		else if (trans)
			phase_r <= (CW+1)'(1);
		else if (phase_r >= full - (CW+1)'(1))
			phase_r <= '0;
		else
			phase_r <= phase_r + (CW+1)'(1);
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			sample_pulse <= 1'b0;
		else
			sample_pulse <= enable && !trans && phase_r == {1'b0, half_period};
	end
endmodule
`default_nettype wire

// *** wan_line_coder.sv ***
// Purpose: serial line encoder/decoder with clock-source and connector selection
// Assumes: all pin inputs are asynchronous to clk; user bit ports are on clk
// Notes: registers at CTRL, STAT, DIV; unmapped reads return zero
// Behaviour
// - NRZ sends one as mark, zero as space; receive decodes alike.
// - NRZ zero bit always equals space level, both directions.
// - NRZI keeps the level for a one; no change reads as one.
// - NRZI toggles the level for a zero; a change reads as zero.
// - four clock modes: NRZ clocked, external transmit clock, NRZI clocked, NRZI recovered.
// - external transmit clock mode: DTE generates and drives transmit timing.
// - unclocked NRZI takes bit timing from transitions of received data.
// - software sets the port as DTE, DCE or passive monitor.
// - exactly one connector active; all others held at high impedance.
`default_nettype none
`include "line_coder_defines.svh"
module wan_line_coder #(
	parameter int NUM_CONN = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [`LC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// user transmit bits
	input wire logic tx_bit,
	output logic tx_bit_take,
	// user receive bits
	output logic rx_bit,
	output logic rx_bit_valid,
	// transmitted data pins
	input wire logic [NUM_CONN-1:0] send_data_in,
	output logic [NUM_CONN-1:0] send_data_out,
	output logic [NUM_CONN-1:0] send_data_oe,
	// received data pins
	input wire logic [NUM_CONN-1:0] recv_data_in,
	output logic [NUM_CONN-1:0] recv_data_out,
	output logic [NUM_CONN-1:0] recv_data_oe,
	// transmit timing from dce pins
	input wire logic [NUM_CONN-1:0] tx_timing_in,
	output logic [NUM_CONN-1:0] tx_timing_out,
	output logic [NUM_CONN-1:0] tx_timing_oe,
	// receive timing from dce pins
	input wire logic [NUM_CONN-1:0] rx_timing_in,
	output logic [NUM_CONN-1:0] rx_timing_out,
	output logic [NUM_CONN-1:0] rx_timing_oe,
	// transmit timing to dce pins
	input wire logic [NUM_CONN-1:0] term_timing_in,
	output logic [NUM_CONN-1:0] term_timing_out,
	output logic [NUM_CONN-1:0] term_timing_oe
);
	// a zero half period would stall the divider, so it counts as one
	function automatic logic [`LC_DIV_W-1:0] half_of(input logic [`LC_DIV_W-1:0] d);
		half_of = (d == '0) ? `LC_DIV_W'(1) : d;
	endfunction

	logic [`LC_CTRL_W-1:0] ctrl_r;
	logic [`LC_DIV_W-1:0] div_r;
	line_coder_pkg::clk_mode_t mode;
	line_coder_pkg::port_role_t role;
	logic [1:0] conn;
	logic [`LC_DIV_W-1:0] half;

	assign mode = line_coder_pkg::clk_mode_t'(ctrl_r[`LC_MODE_MSB:`LC_MODE_LSB]);
	assign role = line_coder_pkg::port_role_t'(ctrl_r[`LC_ROLE_MSB:`LC_ROLE_LSB]);
	assign conn = ctrl_r[`LC_CONN_MSB:`LC_CONN_LSB];
	assign half = half_of(div_r);

	// pin synchronisers
	logic [NUM_CONN-1:0] td_s, rd_s, st_s, rt_s;

	level_sync #(.W(NUM_CONN)) u_sync_td (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(send_data_in),
		.sync_out(td_s)
	);
	level_sync #(.W(NUM_CONN)) u_sync_rd (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(recv_data_in),
		.sync_out(rd_s)
	);
	level_sync #(.W(NUM_CONN)) u_sync_st (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(tx_timing_in),
		.sync_out(st_s)
	);
	level_sync #(.W(NUM_CONN)) u_sync_rt (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(rx_timing_in),
		.sync_out(rt_s)
	);

	// only the active connector is listened to
	logic sel_td, sel_rd, sel_st, sel_rt, rx_line;

	assign sel_td = td_s[conn];
	assign sel_rd = rd_s[conn];
	assign sel_st = st_s[conn];
	assign sel_rt = rt_s[conn];
	assign rx_line = (role == line_coder_pkg::ROLE_DCE) ? sel_td : sel_rd;

	// edges of the dce clocks
	logic st_prev_r, rt_prev_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_prev_r <= 1'b0;
			rt_prev_r <= 1'b0;
		end else begin
			st_prev_r <= sel_st;
			rt_prev_r <= sel_rt;
		end
	end

	// internal bit clock divider
	logic [`LC_DIV_W-1:0] hp_cnt_r;
	logic int_clk_r;
	logic hp_wrap, int_rise, int_fall;

	assign hp_wrap = hp_cnt_r >= half - `LC_DIV_W'(1);
	assign int_rise = hp_wrap && !int_clk_r;
	assign int_fall = hp_wrap && int_clk_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hp_cnt_r <= '0;
			int_clk_r <= 1'b0;
		end else if (hp_wrap) begin
			hp_cnt_r <= '0;
			int_clk_r <= !int_clk_r;
		end else begin
			hp_cnt_r <= hp_cnt_r + `LC_DIV_W'(1);
		end
	end

	// transition-tracking recovery
	logic rec_en, rec_pulse;

	assign rec_en = mode == line_coder_pkg::MODE_NRZI_REC && role != line_coder_pkg::ROLE_SPARE;

	edge_phase_tracker #(.CW(`LC_DIV_W)) u_track (
		.clk(clk),
		.reset_n(reset_n),
		.enable(rec_en),
		.half_period(half),
		.line(rx_line),
		.sample_pulse(rec_pulse)
	);

	// choice of transmit and receive strobes
	logic tx_stb, rx_stb, nrzi;

	assign nrzi = mode == line_coder_pkg::MODE_NRZI_CLK || mode == line_coder_pkg::MODE_NRZI_REC;

	always_comb begin
		tx_stb = 1'b0;
		rx_stb = 1'b0;
		unique case (role)
			line_coder_pkg::ROLE_DTE: begin
				// dte changes data on the falling edge so the dce samples mid-bit
				if (mode == line_coder_pkg::MODE_NRZ_CLK || mode == line_coder_pkg::MODE_NRZI_CLK)
					tx_stb = !sel_st && st_prev_r;
				else
					tx_stb = int_fall;
				if (rec_en)
					rx_stb = rec_pulse;
				else
					rx_stb = sel_rt && !rt_prev_r;
			end
			line_coder_pkg::ROLE_DCE: begin
				tx_stb = int_fall;
				rx_stb = rec_en ? rec_pulse : int_rise;
			end
			line_coder_pkg::ROLE_MON: begin
				rx_stb = rec_en ? rec_pulse : (sel_rt && !rt_prev_r);
			end
			line_coder_pkg::ROLE_SPARE: begin
				rx_stb = 1'b0;
			end
		endcase
	end

	// encoder; idle line rests at mark
	logic tx_line_r;
	logic [`LC_CNT_W-1:0] tx_cnt_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_line_r <= 1'b1;
		end else if (tx_stb) begin
			if (!nrzi)
				tx_line_r <= tx_bit;
			else if (!tx_bit)
				tx_line_r <= !tx_line_r;
			else
				tx_line_r <= tx_line_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_bit_take <= 1'b0;
			tx_cnt_r <= '0;
		end else begin
			tx_bit_take <= tx_stb;
			if (tx_stb)
				tx_cnt_r <= tx_cnt_r + `LC_CNT_W'(1);
		end
	end

	// decoder
	logic rx_prev_r;
	logic [`LC_CNT_W-1:0] rx_cnt_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_prev_r <= 1'b1;
			rx_bit <= 1'b1;
			rx_bit_valid <= 1'b0;
			rx_cnt_r <= '0;
		end else begin
			rx_bit_valid <= rx_stb;
			if (rx_stb) begin
				rx_prev_r <= rx_line;
				rx_cnt_r <= rx_cnt_r + `LC_CNT_W'(1);
				if (nrzi)
					rx_bit <= !(rx_line ^ rx_prev_r);
				else
					rx_bit <= rx_line;
			end
		end
	end

	// pin drivers: all connectors but the selected one float
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			send_data_out <= '0;
			send_data_oe <= '0;
			recv_data_out <= '0;
			recv_data_oe <= '0;
			tx_timing_out <= '0;
			tx_timing_oe <= '0;
			rx_timing_out <= '0;
			rx_timing_oe <= '0;
			term_timing_out <= '0;
			term_timing_oe <= '0;
		end else begin
			for (int i = 0; i < NUM_CONN; i++) begin
				send_data_out[i] <= tx_line_r;
				recv_data_out[i] <= tx_line_r;
				tx_timing_out[i] <= int_clk_r;
				rx_timing_out[i] <= int_clk_r;
				term_timing_out[i] <= int_clk_r;
				if (2'(i) == conn) begin
					send_data_oe[i] <= role == line_coder_pkg::ROLE_DTE;
					term_timing_oe[i] <= role == line_coder_pkg::ROLE_DTE &&
						mode == line_coder_pkg::MODE_EXT_TX;
					recv_data_oe[i] <= role == line_coder_pkg::ROLE_DCE;
					tx_timing_oe[i] <= role == line_coder_pkg::ROLE_DCE;
					rx_timing_oe[i] <= role == line_coder_pkg::ROLE_DCE && !rec_en;
				end else begin
					send_data_oe[i] <= 1'b0;
					term_timing_oe[i] <= 1'b0;
					recv_data_oe[i] <= 1'b0;
					tx_timing_oe[i] <= 1'b0;
					rx_timing_oe[i] <= 1'b0;
				end
			end
		end
	end

	// register writes; a connector index beyond the fitted ones is ignored
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_r <= `LC_CTRL_RST;
		end else if (reg_wr && reg_addr == `LC_CTRL_ADDR) begin
			ctrl_r[`LC_ROLE_MSB:0] <= reg_wdata[`LC_ROLE_MSB:0];
			if (32'(reg_wdata[`LC_CONN_MSB:`LC_CONN_LSB]) < NUM_CONN)
				ctrl_r[`LC_CONN_MSB:`LC_CONN_LSB] <= reg_wdata[`LC_CONN_MSB:`LC_CONN_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			div_r <= `LC_DIV_RST;
		else if (reg_wr && reg_addr == `LC_DIV_ADDR)
			div_r <= reg_wdata[`LC_DIV_W-1:0];
	end

	// register reads, data valid the cycle after the strobe only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					`LC_CTRL_ADDR: reg_rdata <= 32'(ctrl_r);
					`LC_DIV_ADDR: reg_rdata <= 32'(div_r);
					`LC_STAT_ADDR: begin
						reg_rdata[`LC_ST_RXBIT] <= rx_bit;
						reg_rdata[`LC_ST_TXLINE] <= tx_line_r;
						reg_rdata[`LC_ST_REC] <= rec_en;
						reg_rdata[`LC_ST_RXCNT_MSB:`LC_ST_RXCNT_LSB] <= rx_cnt_r;
						reg_rdata[`LC_ST_TXCNT_MSB:`LC_ST_TXCNT_LSB] <= tx_cnt_r;
					end
					default: reg_rdata <= '0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** wan_line_coder_checker.sv ***
// Purpose: port-level checks of the line coder
// Assumes: bound into wan_line_coder
// Notes: mode and role are internal, so checks lean on pin and strobe relations
`default_nettype none
module wan_line_coder_checker #(
	parameter int NUM_CONN = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// bus and user side
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic tx_bit_take,
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	// pins
	input wire logic [NUM_CONN-1:0] send_data_out,
	input wire logic [NUM_CONN-1:0] send_data_oe,
	input wire logic [NUM_CONN-1:0] recv_data_oe,
	input wire logic [NUM_CONN-1:0] tx_timing_oe,
	input wire logic [NUM_CONN-1:0] rx_timing_oe,
	input wire logic [NUM_CONN-1:0] term_timing_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [NUM_CONN-1:0] any_oe;
	assign any_oe = send_data_oe | recv_data_oe | tx_timing_oe | rx_timing_oe | term_timing_oe;
	sequence one_shot(s);
		s ##1 !s;
	endsequence
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside read reply");
	chk_one_conn: assert property ($onehot0(any_oe))
		else $error("more than one connector driven");
	chk_roles_excl: assert property (!((|send_data_oe) && (|recv_data_oe)))
		else $error("dte and dce drivers both on");
	chk_take_pulse: assert property (tx_bit_take |-> one_shot(tx_bit_take))
		else $error("bit take longer than one cycle");
	chk_valid_pulse: assert property (rx_bit_valid |-> one_shot(rx_bit_valid))
		else $error("receive strobe longer than one cycle");
	chk_rxbit_hold: assert property ($changed(rx_bit) |-> rx_bit_valid)
		else $error("received bit moved without strobe");
	chk_term_with_data: assert property (|term_timing_oe |-> send_data_oe == term_timing_oe)
		else $error("transmit timing driven apart from data");
	// a line step on a steady driver must come from a taken bit
	chk_line_after_take: assert property ($changed(send_data_out) && $stable(send_data_oe)
		&& (|send_data_oe) |-> $past(tx_bit_take))
		else $error("line level moved without a bit");
endmodule
bind wan_line_coder wan_line_coder_checker #(.NUM_CONN(NUM_CONN)) u_wan_line_coder_checker (
	.clk, .reset_n, .reg_rd, .reg_rdata, .tx_bit_take, .rx_bit, .rx_bit_valid,
	.send_data_out, .send_data_oe, .recv_data_oe, .tx_timing_oe, .rx_timing_oe,
	.term_timing_oe);
`default_nettype wire

// *** dce_model.sv ***
// Purpose: far-end dce giving bit clocks and received line levels
// Assumes: levels are prepared by the bench
// Notes: clock stands low while idle; line idles at mark
`default_nettype none
module dce_model (
	// control
	input wire logic run,
	input wire logic [7:0] lv,
	// pins
	output logic tck,
	output logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	int idx;
	initial begin
		tck = 1'b0;
		line = 1'b1;
		idx = 0;
		#7;
		forever begin
			#100;
			// dce owns the bit clocks; data moves on the fall, safe for rise sampling
			tck = run ? ~tck : 1'b0;
			if (!run) begin
				idx = 0;
				line = 1'b1;
			end else if (!tck) begin
				line = (idx < 8) ? lv[idx] : 1'b1;
				idx++;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench of the line coder
// Assumes: one dce model wired to every connector
// Notes: traffic is judged on connector 0 only
`default_nettype none
`include "line_coder_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, reg_wr, reg_rd, tx_bit, tx_bit_take, rx_bit, rx_bit_valid;
	logic run, tck, mline;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [7:0] lv;
	logic [2:0] sd_o, sd_e, rd_o, rd_e, tt_o, tt_e, rt_o, rt_e, te_o, te_e;
	int err_total, total_checks, cyc, te_cnt;
	// undriven send data and terminal timing pins read back inverted so stale values never pass; other undriven pins read the dce model
	wan_line_coder u_wan_line_coder (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .tx_bit, .tx_bit_take, .rx_bit, .rx_bit_valid,
		.send_data_in(~(sd_e ^ sd_o)), .send_data_out(sd_o), .send_data_oe(sd_e),
		.recv_data_in((rd_e & rd_o) | (~rd_e & {3{mline}})), .recv_data_out(rd_o),
		.recv_data_oe(rd_e), .tx_timing_in((tt_e & tt_o) | (~tt_e & {3{tck}})),
		.tx_timing_out(tt_o), .tx_timing_oe(tt_e),
		.rx_timing_in((rt_e & rt_o) | (~rt_e & {3{tck}})), .rx_timing_out(rt_o),
		.rx_timing_oe(rt_e), .term_timing_in(~(te_e ^ te_o)), .term_timing_out(te_o),
		.term_timing_oe(te_e));
	dce_model u_dce_model (.run, .lv, .tck, .line(mline));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(te_o[0]) te_cnt++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic setc(logic [1:0] c, logic [1:0] r, logic [1:0] m);
		wr(`LC_CTRL_ADDR, {26'h0, c, r, m});
	endtask
	task automatic t_regs();
		logic [31:0] d;
		rd(`LC_CTRL_ADDR, d);
		chk("ctrl", d, 32'(`LC_CTRL_RST));
		rd(`LC_DIV_ADDR, d);
		chk("div", d, 32'(`LC_DIV_RST));
		wr(4'hC, 32'hFFFF_FFFF);
		rd(4'hC, d);
		chk("unmapped", d, 32'h0);
		rd(`LC_CTRL_ADDR, d);
		chk("ctrl_kept", d, 32'h0);
	endtask
	task automatic t_oe();
		for (int c = 0; c < 3; c++) begin
			for (int r = 0; r < 4; r++) begin
				setc(2'(c), 2'(r), line_coder_pkg::MODE_EXT_TX);
				repeat (2) @(posedge clk);
				#1;
				chk("send_oe", 32'(sd_e), (r == 0) ? 32'(1 << c) : 32'h0);
				chk("recv_oe", 32'(rd_e), (r == 1) ? 32'(1 << c) : 32'h0);
				chk("term_oe", 32'(te_e), (r == 0) ? 32'(1 << c) : 32'h0);
				chk("txtim_oe", 32'(tt_e), (r == 1) ? 32'(1 << c) : 32'h0);
				chk("rxtim_oe", 32'(rt_e), (r == 1) ? 32'(1 << c) : 32'h0);
				chk("recv_mark", 32'(rd_o[c]), 32'h1);
			end
		end
		setc(2'h3, 2'h0, line_coder_pkg::MODE_EXT_TX);
		repeat (2) @(posedge clk);
		#1;
		chk("conn_keep", 32'(sd_e), 32'h4);
	endtask
	// patterns start with a one, and tx_bit holds bit 0 outside the loop, so strobes there leave the line at mark
	task automatic t_tx(logic [1:0] m, logic [7:0] p);
		logic lvl;
		int n;
		lvl = 1'b1;
		@(posedge clk);
		tx_bit <= p[0];
		run <= 1'b1;
		setc(2'h0, line_coder_pkg::ROLE_DTE, m);
		te_cnt = 0;
		for (int i = 0; i < 8; i++) begin
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (tx_bit_take !== 1'b1 && n < 60);
			lvl = m[1] ? lvl ^ ~p[i] : p[i];
			@(posedge clk);
			tx_bit <= p[(i + 1) % 8];
			#1;
			chk("line", 32'(sd_o[0]), 32'(lvl));
		end
		if (!m[1]) chk("term_clk", 32'(te_cnt > 10), 32'h1);
		if (!m[1]) chk("term_drv", 32'(te_e[0]), 32'h1);
		@(posedge clk);
		run <= 1'b0;
		// the far end only rewinds its pattern when it sees run low at a tick
		repeat (10) @(posedge clk);
	endtask
	// alignment is unknown, so the pattern is searched for in the received window
	task automatic t_rx(logic [1:0] m, logic [7:0] p);
		logic [31:0] w, d;
		logic lvl, hit;
		lvl = 1'b1;
		w = 32'hFFFF_FFFF;
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			lvl = m[1] ? lvl ^ ~p[i] : p[i];
			lv[i] = lvl;
		end
		setc(2'h0, line_coder_pkg::ROLE_DTE, m);
		rd(`LC_STAT_ADDR, d);
		chk("rec_on", 32'(d[`LC_ST_REC]), 32'(m == line_coder_pkg::MODE_NRZI_REC));
		run <= 1'b1;
		repeat (110) begin
			@(posedge clk);
			#1;
			if (rx_bit_valid === 1'b1) w = {rx_bit, w[31:1]};
		end
		@(posedge clk);
		run <= 1'b0;
		repeat (10) @(posedge clk);
		for (int k = 0; k < 25; k++) hit |= (w[k+:8] === p);
		chk("rx_bits", 32'(hit), 32'h1);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		tx_bit = 1'b1;
		run = 1'b0;
		lv = 8'hFF;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_oe();
		t_tx(line_coder_pkg::MODE_EXT_TX, 8'hB5);
		t_tx(line_coder_pkg::MODE_NRZI_CLK, 8'h4D);
		t_rx(line_coder_pkg::MODE_NRZ_CLK, 8'h2C);
		t_rx(line_coder_pkg::MODE_NRZI_CLK, 8'h2C);
		t_rx(line_coder_pkg::MODE_NRZI_REC, 8'h2C);
		complete_run();
	end
endmodule
`default_nettype wire
